/* File: logic/flpc_pkg.sv */
`default_nettype none
package flpc_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] FPC_IDX   = 10'h0d1;
  localparam logic [9:0] EEC_IDX   = 10'h0d2;
  localparam logic [9:0] EWT_IDX   = 10'h0d3;
  localparam logic [9:0] STAT_IDX  = 10'h0e0;
  localparam logic [9:0] MASK_IDX  = 10'h0e1;
  localparam logic [9:0] CFG_IDX   = 10'h0e2;
  localparam int AXI_AW = 12;
  // field positions
  localparam int KEY_LSB  = 4;
  localparam int FMAP_BIT = 3;
  localparam int SEL_LSB  = 1;
  localparam int EMAP_BIT = 1;
  localparam int BUSY_BIT = 0;
  localparam logic [3:0] KEY_FIRST  = 4'h5;
  localparam logic [3:0] KEY_SECOND = 4'ha;
  localparam logic [3:0] KEY_NONE   = 4'h0;
  localparam logic [1:0] SEL_USER = 2'h0;
  localparam logic [1:0] SEL_XPG  = 2'h1;
  localparam logic [1:0] SEL_SEC  = 2'h2;
  // reset and erased values
  localparam logic [7:0] EWT_RST    = 8'h00;
  localparam logic [1:0] SEL_RST    = 2'h0;
  localparam logic [7:0] SEC_ERASED = 8'hff;
  // flash geometry
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_COUNT = 512;
  localparam int BYTE_W     = $clog2(PAGE_BYTES);
  localparam int PAGE_W     = $clog2(PAGE_COUNT);
  localparam logic [15:0] BOOT_BASE = 16'hfc00;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_MS  = 10;
  localparam int PROG_CYCLES   = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W = 20;
  // interrupt status bits
  localparam int IRQ_FDONE = 0;
  localparam int IRQ_EDONE = 1;
  localparam int IRQ_ABORT = 2;
  localparam int IRQ_W     = 3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : flpc_pkg
`default_nettype wire

/* File: logic/flpc_flash_program_control.sv */
// Contract
// - write timer register resets to zero
// - flash is 512 pages of 128 bytes
// - every program cycle erases its target before writing
// - top kilobyte holds loader code; application uses lower 63 Kbytes
// - programming starts only after key 5h then key Ah
// - map bit steers data moves to column latches and code reads to flash; code reads here ignore the map bit and follow only the external access pin
// - space select: 00 user, 01 extra page, 10 security byte, 11 reserved
// - busy flag set and cleared by hardware only
// - reset clears map, select and busy; key nibble undefined
// - security byte reads all ones after full erase, bits active low
// - security byte reachable only through parallel programming modes
// - flash byte reads insert no wait states
// - a program cycle takes 10 ms with busy held set
// - external access low fetches all code from external memory
// - extra page reachable only through its own space selection
// - eeprom launched by 5X then AX; eeprom busy held until done
`default_nettype none

module flpc_launch #(
  parameter int CNT_W = 20
) (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             ce_i,
  input  wire logic             key_wr_i,
  input  wire logic [3:0]       key_i,
  input  wire logic [CNT_W-1:0] len_i,
  output logic                  busy_o,
  output logic                  start_o,
  output logic                  done_o,
  output logic                  abort_o,
  output logic [CNT_W-1:0]      cnt_o
);
  typedef enum {KEY_IDLE, KEY_ARMED, KEY_RUN} flpc_key_e;
  flpc_key_e        state_reg, state_next;
  logic [CNT_W-1:0] cnt_next;
  logic             start_next, done_next, abort_next;
  wire key_first  = key_wr_i && (key_i == flpc_pkg::KEY_FIRST);
  wire key_second = key_wr_i && (key_i == flpc_pkg::KEY_SECOND);
  wire last_cnt   = (cnt_o == CNT_W'(1));

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_o;
    start_next = 1'b0;
    done_next  = 1'b0;
    abort_next = 1'b0;
    case (state_reg)
      KEY_IDLE: begin
        if (key_first) state_next = KEY_ARMED;
      end
      KEY_ARMED: begin
        if (key_second) begin
          state_next = KEY_RUN;
          cnt_next   = (len_i == '0) ? CNT_W'(1) : len_i;
          start_next = 1'b1;
        end else if (key_wr_i && !key_first) begin
          state_next = KEY_IDLE;
          abort_next = 1'b1;
        end
      end
      KEY_RUN: begin
        // key writes while running are ignored
        if (last_cnt) begin
          state_next = KEY_IDLE;
          done_next  = 1'b1;
        end
        cnt_next = cnt_o - CNT_W'(1);
      end
      default: state_next = KEY_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= KEY_IDLE;
      cnt_o     <= '0;
      busy_o    <= 1'b0;
      start_o   <= 1'b0;
      done_o    <= 1'b0;
      abort_o   <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      cnt_o     <= cnt_next;
      busy_o    <= (state_next == KEY_RUN);
      start_o   <= start_next;
      done_o    <= done_next;
      abort_o   <= abort_next;
    end
  end
endmodule // flpc_launch

module flpc_flash_program_control #(
  parameter int PROG_CYCLES = flpc_pkg::PROG_CYCLES,
  parameter int EE_TICK     = 1000
) (
  input  wire logic                      clk_i,
  input  wire logic                      arst_n_i,
  input  wire logic                      ce_i,
  input  wire logic [flpc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [flpc_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      external_access_select_n_i,
  input  wire logic                      xmove_wr_i,
  input  wire logic [15:0]               xmove_addr_i,
  input  wire logic [7:0]                xmove_data_i,
  input  wire logic                      code_rd_i,
  input  wire logic [15:0]               code_addr_i,
  input  wire logic                      par_mode_i,
  input  wire logic                      par_erase_i,
  input  wire logic                      par_sec_wr_i,
  input  wire logic [7:0]                par_sec_data_i,
  output logic                           data_wr_o,
  output logic                           col_latch_wr_o,
  output logic                           ee_latch_wr_o,
  output logic [1:0]                     latch_space_o,
  output logic [flpc_pkg::PAGE_W-1:0]    latch_page_o,
  output logic [flpc_pkg::BYTE_W-1:0]    latch_byte_o,
  output logic [15:0]                    move_addr_o,
  output logic [7:0]                     move_data_o,
  output logic                           code_flash_rd_o,
  output logic                           code_ext_fetch_o,
  output logic [15:0]                    code_addr_o,
  output logic                           flash_prog_start_o,
  output logic                           flash_erase_phase_o,
  output logic                           flash_busy_flag_o,
  output logic                           eeprom_busy_flag_o,
  output logic [7:0]                     hardware_security_byte_o,
  output logic                           irq_o
);
  localparam int CW = flpc_pkg::CNT_W;
  localparam int EW = flpc_pkg::IRQ_W;

  logic [3:0] flash_launch_key_reg, eeprom_key_reg;
  logic       flash_space_map_reg, eeprom_map_reg, boot_wr_en_reg;
  logic [1:0] flash_space_select_reg;
  logic [7:0] eeprom_write_timer_reg;
  logic [EW-1:0] irq_stat_reg, irq_mask_reg;
  logic       xa_s1_reg, xa_s2_reg, xa_s3_reg, xa_state_reg;
  logic       awready_reg, arready_reg;
  logic       fl_busy, fl_done, fl_abort, ee_busy, ee_done, ee_abort;
  logic [CW-1:0] fl_cnt;
  logic [31:0]   rd_data;

  // bus decode
  wire wr_go   = s_axi_awvalid && s_axi_wvalid && !awready_reg && !s_axi_bvalid;
  wire rd_go   = s_axi_arvalid && !arready_reg && !s_axi_rvalid;
  wire wr_fire = awready_reg;
  wire rd_fire = arready_reg;
  wire [9:0] w_idx = s_axi_awaddr[flpc_pkg::AXI_AW-1:2];
  wire [9:0] r_idx = s_axi_araddr[flpc_pkg::AXI_AW-1:2];
  wire [7:0] wd    = s_axi_wdata[7:0];
  wire       wen   = wr_fire && s_axi_wstrb[0];
  wire hit_fpc   = wen && (w_idx == flpc_pkg::FPC_IDX);
  wire hit_eec   = wen && (w_idx == flpc_pkg::EEC_IDX);
  wire hit_ewt   = wen && (w_idx == flpc_pkg::EWT_IDX);
  wire hit_stat  = wen && (w_idx == flpc_pkg::STAT_IDX);
  wire hit_mask  = wen && (w_idx == flpc_pkg::MASK_IDX);
  wire hit_cfg   = wen && (w_idx == flpc_pkg::CFG_IDX);
  wire w_mapped  = (w_idx == flpc_pkg::FPC_IDX) || (w_idx == flpc_pkg::EEC_IDX)
                || (w_idx == flpc_pkg::EWT_IDX) || (w_idx == flpc_pkg::STAT_IDX)
                || (w_idx == flpc_pkg::MASK_IDX) || (w_idx == flpc_pkg::CFG_IDX);
  wire r_mapped  = (r_idx == flpc_pkg::FPC_IDX) || (r_idx == flpc_pkg::EEC_IDX)
                || (r_idx == flpc_pkg::EWT_IDX) || (r_idx == flpc_pkg::STAT_IDX)
                || (r_idx == flpc_pkg::MASK_IDX) || (r_idx == flpc_pkg::CFG_IDX);
  wire [7:0] fpc_rd = {flash_launch_key_reg, flash_space_map_reg,
                       flash_space_select_reg, fl_busy};
  wire [7:0] eec_rd = {eeprom_key_reg, 2'h0, eeprom_map_reg, ee_busy};
  assign rd_data =
      (r_idx == flpc_pkg::FPC_IDX)   ? {24'h0, fpc_rd} :
      (r_idx == flpc_pkg::EEC_IDX)   ? {24'h0, eec_rd} :
      (r_idx == flpc_pkg::EWT_IDX)   ? {24'h0, eeprom_write_timer_reg} :
      (r_idx == flpc_pkg::STAT_IDX)  ? {{(32-EW){1'b0}}, irq_stat_reg} :
      (r_idx == flpc_pkg::MASK_IDX)  ? {{(32-EW){1'b0}}, irq_mask_reg} :
      (r_idx == flpc_pkg::CFG_IDX)   ? {31'h0, boot_wr_en_reg} : 32'h0;

  // launch keys; security byte and reserved space cannot be launched
  wire [1:0] wsel   = wd[flpc_pkg::SEL_LSB +: 2];
  wire       sel_ok = (wsel == flpc_pkg::SEL_USER) || (wsel == flpc_pkg::SEL_XPG);
  wire [3:0] fl_key = sel_ok ? wd[flpc_pkg::KEY_LSB +: 4] : flpc_pkg::KEY_NONE;
  wire [CW-1:0] fl_len = CW'(PROG_CYCLES);
  wire [CW-1:0] ee_len = CW'(eeprom_write_timer_reg * EE_TICK);

  flpc_launch #(.CNT_W(CW)) u_flash (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .ce_i     (ce_i),
    .key_wr_i (hit_fpc),
    .key_i    (fl_key),
    .len_i    (fl_len),
    .busy_o   (fl_busy),
    .start_o  (flash_prog_start_o),
    .done_o   (fl_done),
    .abort_o  (fl_abort),
    .cnt_o    (fl_cnt)
  );

  flpc_launch #(.CNT_W(CW)) u_eeprom (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .ce_i     (ce_i),
    .key_wr_i (hit_eec),
    .key_i    (wd[flpc_pkg::KEY_LSB +: 4]),
    .len_i    (ee_len),
    .busy_o   (ee_busy),
    .start_o  (),
    .done_o   (ee_done),
    .abort_o  (ee_abort),
    .cnt_o    ()
  );
  assign flash_busy_flag_o  = fl_busy;
  assign eeprom_busy_flag_o = ee_busy;

  // data move and code read routing
  wire in_boot  = (xmove_addr_i >= flpc_pkg::BOOT_BASE) && !boot_wr_en_reg;
  wire fl_space = (flash_space_select_reg == flpc_pkg::SEL_XPG)
               || ((flash_space_select_reg == flpc_pkg::SEL_USER) && !in_boot);
  wire fl_wr    = xmove_wr_i && flash_space_map_reg;
  wire ee_wr    = xmove_wr_i && !flash_space_map_reg && eeprom_map_reg;
  wire dat_wr   = xmove_wr_i && !flash_space_map_reg && !eeprom_map_reg;
  wire [EW-1:0] ev = {(fl_abort || ee_abort), ee_done, fl_done};

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      awready_reg   <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= flpc_pkg::RESP_OKAY;
    end else if (ce_i) begin
      awready_reg   <= wr_go;
      s_axi_wready  <= wr_go;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_mapped ? flpc_pkg::RESP_OKAY : flpc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = awready_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arready_reg  <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= flpc_pkg::RESP_OKAY;
    end else if (ce_i) begin
      arready_reg <= rd_go;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= r_mapped ? flpc_pkg::RESP_OKAY : flpc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  assign s_axi_arready = arready_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flash_launch_key_reg   <= flpc_pkg::KEY_NONE;
      flash_space_map_reg    <= 1'b0;
      flash_space_select_reg <= flpc_pkg::SEL_RST;
      eeprom_key_reg         <= flpc_pkg::KEY_NONE;
      eeprom_map_reg         <= 1'b0;
      eeprom_write_timer_reg <= flpc_pkg::EWT_RST;
      irq_mask_reg           <= '0;
      boot_wr_en_reg         <= 1'b0;
    end else if (ce_i) begin
      if (hit_fpc) begin
        // busy bit is not writable
        flash_launch_key_reg   <= wd[flpc_pkg::KEY_LSB +: 4];
        flash_space_map_reg    <= wd[flpc_pkg::FMAP_BIT];
        flash_space_select_reg <= wsel;
      end
      if (hit_eec) begin
        eeprom_key_reg <= wd[flpc_pkg::KEY_LSB +: 4];
        eeprom_map_reg <= wd[flpc_pkg::EMAP_BIT];
      end
      if (hit_ewt) eeprom_write_timer_reg <= wd;
      if (hit_mask) irq_mask_reg <= wd[EW-1:0];
      if (hit_cfg) boot_wr_en_reg <= wd[0];
    end
  end

  // sticky events, write one to clear, a new event wins
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat_reg <= '0;
      irq_o        <= 1'b0;
    end else if (ce_i) begin
      irq_stat_reg <= (irq_stat_reg & ~(hit_stat ? wd[EW-1:0] : '0)) | ev;
      irq_o        <= |(((irq_stat_reg & ~(hit_stat ? wd[EW-1:0] : '0)) | ev)
                        & irq_mask_reg);
    end
  end

  // external access pin: three stages, second and third must agree
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      xa_s1_reg    <= 1'b1;
      xa_s2_reg    <= 1'b1;
      xa_s3_reg    <= 1'b1;
      xa_state_reg <= 1'b1;
    end else if (ce_i) begin
      xa_s1_reg <= external_access_select_n_i;
      xa_s2_reg <= xa_s1_reg;
      xa_s3_reg <= xa_s2_reg;
      if (xa_s2_reg == xa_s3_reg) xa_state_reg <= xa_s3_reg;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_wr_o        <= 1'b0;
      col_latch_wr_o   <= 1'b0;
      ee_latch_wr_o    <= 1'b0;
      latch_space_o    <= flpc_pkg::SEL_RST;
      latch_page_o     <= '0;
      latch_byte_o     <= '0;
      move_addr_o      <= 16'h0;
      move_data_o      <= 8'h0;
      code_flash_rd_o  <= 1'b0;
      code_ext_fetch_o <= 1'b0;
      code_addr_o      <= 16'h0;
    end else if (ce_i) begin
      data_wr_o      <= dat_wr;
      col_latch_wr_o <= fl_wr && fl_space;
      ee_latch_wr_o  <= ee_wr;
      latch_space_o  <= flash_space_select_reg;
      latch_page_o   <= xmove_addr_i[15 -: flpc_pkg::PAGE_W];
      latch_byte_o   <= xmove_addr_i[flpc_pkg::BYTE_W-1:0];
      move_addr_o    <= xmove_addr_i;
      move_data_o    <= xmove_data_i;
      // one fixed cycle for every code read, never stretched
      code_flash_rd_o  <= code_rd_i && xa_state_reg;
      code_ext_fetch_o <= code_rd_i && !xa_state_reg;
      code_addr_o      <= code_addr_i;
    end
  end

  // first half of a cycle erases, second half writes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flash_erase_phase_o <= 1'b0;
    end else if (ce_i) begin
      flash_erase_phase_o <= fl_busy && (fl_cnt > CW'(PROG_CYCLES / 2));
    end
  end

  // security byte: parallel programming access only, erased to all ones
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hardware_security_byte_o <= flpc_pkg::SEC_ERASED;
    end else if (ce_i && par_mode_i) begin
      if (par_erase_i) hardware_security_byte_o <= flpc_pkg::SEC_ERASED;
      else if (par_sec_wr_i) hardware_security_byte_o <= par_sec_data_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i || !ce_i);

  timer_reset_a: assert property (
    !$past(arst_n_i) |-> eeprom_write_timer_reg == flpc_pkg::EWT_RST)
    else $error("write timer not zero after reset");
  key_launch_a: assert property (
    flash_prog_start_o |-> $past(hit_fpc && fl_key == flpc_pkg::KEY_SECOND))
    else $error("flash started without second key");
  key_abort_a: assert property (
    hit_fpc && !fl_busy && fl_key != flpc_pkg::KEY_SECOND |=> !flash_prog_start_o)
    else $error("flash started on a wrong key");
  busy_end_a: assert property (
    fl_busy && fl_cnt == CW'(1) |=> !fl_busy && fl_done)
    else $error("busy did not end with the count");
  busy_hold_a: assert property (
    hit_fpc && fl_busy && fl_cnt > CW'(1) |=> fl_busy)
    else $error("software write cleared busy");
  erase_first_a: assert property (
    $rose(fl_busy) |=> flash_erase_phase_o)
    else $error("program cycle did not begin with erase");
  map_route_a: assert property (
    dat_wr |=> data_wr_o && !col_latch_wr_o && !ee_latch_wr_o)
    else $error("unmapped move not sent to data space");
  sec_guard_a: assert property (
    fl_wr && flash_space_select_reg == flpc_pkg::SEL_SEC |=> !col_latch_wr_o)
    else $error("software reached the security byte");
  ext_fetch_a: assert property (
    code_rd_i && !xa_state_reg |=> code_ext_fetch_o && !code_flash_rd_o)
    else $error("internal read while external access selected");
  ee_busy_a: assert property (
    hit_eec && wd[7:4] == flpc_pkg::KEY_SECOND && $past(ee_busy) == 1'b0
    && !ee_busy ##1 ee_busy |-> ##1 ee_busy || ee_done)
    else $error("eeprom busy dropped early");
  sec_erase_a: assert property (
    par_mode_i && par_erase_i |=> hardware_security_byte_o == flpc_pkg::SEC_ERASED)
    else $error("security byte not all ones after erase");

  launch_c: cover property (hit_fpc ##1 hit_fpc ##1 flash_prog_start_o);
  abort_c:  cover property (fl_abort);
  ee_run_c: cover property ($rose(ee_busy));
  irq_c:    cover property ($rose(irq_o));
endmodule // flpc_flash_program_control
`default_nettype wire

/* File: dv/flpc_cpu_model.sv */
`default_nettype none
module flpc_cpu_model (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        req_i,
  input  wire logic        code_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  data_i,
  output logic             xmove_wr_o,
  output logic [15:0]      xmove_addr_o,
  output logic [7:0]       xmove_data_o,
  output logic             code_rd_o,
  output logic [15:0]      code_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // one-cycle move or code read per request; idle buses toggle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      xmove_wr_o   <= 1'b0;
      code_rd_o    <= 1'b0;
      xmove_addr_o <= '0;
      xmove_data_o <= '0;
      code_addr_o  <= '0;
    end else begin
      xmove_wr_o   <= req_i & ~code_i;
      code_rd_o    <= req_i & code_i;
      xmove_addr_o <= (req_i & ~code_i) ? addr_i : ~xmove_addr_o;
      xmove_data_o <= (req_i & ~code_i) ? data_i : ~xmove_data_o;
      code_addr_o  <= (req_i & code_i) ? addr_i : ~code_addr_o;
    end
  end
endmodule // flpc_cpu_model
`default_nettype wire

/* File: dv/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PC = 20;
  logic clk_i = 1'b0, arst_n_i = 1'b0, ext_n = 1'b1, par_mode = 1'b0, par_erase = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, xwr, crd, req = 1'b0, code_q = 1'b0;
  logic [1:0] bresp, rresp, lsp, r;
  logic sec_wr = 1'b0, dw, cl, el, cf, cx, erase, flash_busy_flag, ebusy, irq, erase_seen = 1'b0;
  logic [7:0] sec_d = '0, xdata, mdata, sec;
  logic [15:0] addr_q = '0, xaddr, caddr, maddr, cad;
  logic [flpc_pkg::PAGE_W-1:0] lpg;
  logic [flpc_pkg::BYTE_W-1:0] lby;
  logic [4:0] seen;
  int fail_count = 0, samples_checked = 0, busy_cyc = 0, lat, n;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (flash_busy_flag === 1'b1) busy_cyc++;
    if (erase === 1'b1) erase_seen = 1'b1;
  end
  flpc_cpu_model i_cpu (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req), .code_i(code_q),
    .addr_i(addr_q), .data_i(8'h3c), .xmove_wr_o(xwr), .xmove_addr_o(xaddr),
    .xmove_data_o(xdata), .code_rd_o(crd), .code_addr_o(caddr));
  flpc_flash_program_control #(.PROG_CYCLES(PC), .EE_TICK(2)) i_dut (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .ce_i(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_access_select_n_i(ext_n), .xmove_wr_i(xwr), .xmove_addr_i(xaddr),
    .xmove_data_i(xdata), .code_rd_i(crd), .code_addr_i(caddr), .par_mode_i(par_mode),
    .par_erase_i(par_erase), .par_sec_wr_i(sec_wr), .par_sec_data_i(sec_d), .data_wr_o(dw),
    .col_latch_wr_o(cl), .ee_latch_wr_o(el), .latch_space_o(lsp), .latch_page_o(lpg),
    .latch_byte_o(lby), .move_addr_o(maddr), .move_data_o(mdata), .code_flash_rd_o(cf),
    .code_ext_fetch_o(cx), .code_addr_o(cad), .flash_prog_start_o(),
    .flash_erase_phase_o(erase),
    .flash_busy_flag_o(flash_busy_flag), .eeprom_busy_flag_o(ebusy), .hardware_security_byte_o(sec),
    .irq_o(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tmo(input string m);
    fail_count++;
    $display("[FAIL] %0t timeout %s", $time, m);
    wrap_up();
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] v);
    @(posedge clk_i);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 40) tmo("write");
  endtask
  task automatic rd(input logic [9:0] idx);
    @(posedge clk_i);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 40) tmo("read");
  endtask
  task automatic mv(input logic c, input logic [15:0] a);
    @(posedge clk_i);
    req <= 1'b1;
    code_q <= c;
    addr_q <= a;
    @(posedge clk_i);
    req <= 1'b0;
    seen = '0;
    for (lat = 0; lat < 6 && seen == 0; lat++) begin
      @(posedge clk_i);
      #1;
      seen = {cl, el, dw, cf, cx};
    end
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  task automatic t_reset();
    rd(flpc_pkg::FPC_IDX);
    chk(d[3:0], 4'h0, "ctrl reset");
    rd(flpc_pkg::EWT_IDX);
    chk(d, {24'h0, flpc_pkg::EWT_RST}, "timer reset");
    chk(sec, flpc_pkg::SEC_ERASED, "security reset");
    rd(10'h0ff);
    chk(r, flpc_pkg::RESP_SLVERR, "unmapped resp");
    chk(d, 32'h0, "unmapped data");
  endtask
  task automatic t_launch();
    busy_cyc = 0;
    wr(flpc_pkg::FPC_IDX, 8'h50);
    chk(flash_busy_flag, 1'b0, "armed only");
    wr(flpc_pkg::FPC_IDX, 8'ha0);
    settle(0);
    chk(flash_busy_flag, 1'b1, "busy set");
    wr(flpc_pkg::FPC_IDX, 8'h00);
    rd(flpc_pkg::FPC_IDX);
    chk(d[0], 1'b1, "busy kept");
    for (lat = 0; lat < 200 && flash_busy_flag !== 1'b0; lat++) @(posedge clk_i);
    if (lat == 200) tmo("flash busy");
    chk(busy_cyc, PC, "prog time");
    chk(erase_seen, 1'b1, "erase phase");
    rd(flpc_pkg::STAT_IDX);
    chk(d[flpc_pkg::IRQ_FDONE], 1'b1, "done event");
    chk(irq, 1'b0, "masked");
    wr(flpc_pkg::MASK_IDX, 8'h07);
    settle(2);
    chk(irq, 1'b1, "irq raised");
    wr(flpc_pkg::STAT_IDX, 8'h01);
    settle(2);
    chk(irq, 1'b0, "irq cleared");
  endtask
  task automatic t_abort();
    wr(flpc_pkg::FPC_IDX, 8'h50);
    wr(flpc_pkg::FPC_IDX, 8'h30);
    settle(2);
    chk({flash_busy_flag, irq}, 2'b01, "abort");
    rd(flpc_pkg::STAT_IDX);
    chk(d[flpc_pkg::IRQ_ABORT], 1'b1, "abort event");
    wr(flpc_pkg::FPC_IDX, 8'ha0);
    settle(2);
    chk(flash_busy_flag, 1'b0, "needs fresh key");
    wr(flpc_pkg::STAT_IDX, 8'h07);
  endtask
  task automatic t_moves();
    wr(flpc_pkg::FPC_IDX, 8'h08);
    mv(1'b0, 16'h1234);
    chk(seen, 5'b10000, "column latch");
    chk(maddr, 16'h1234, "move addr");
    chk({lpg, lby}, {9'h024, 7'h34}, "page and byte");
    chk({lsp, mdata}, {flpc_pkg::SEL_USER, 8'h3c}, "user space");
    mv(1'b0, 16'hfc10);
    chk(seen[4], 1'b0, "loader area");
    mv(1'b1, 16'h0100);
    chk(seen, 5'b00010, "code read");
    chk(lat, 1, "no wait state");
    chk(cad, 16'h0100, "code addr");
    wr(flpc_pkg::FPC_IDX, 8'h0a);
    mv(1'b0, 16'h0005);
    chk({seen, lsp}, {5'b10000, flpc_pkg::SEL_XPG}, "extra page");
    for (int s = 2; s < 4; s++) begin
      wr(flpc_pkg::FPC_IDX, {4'h0, 1'b1, s[1:0], 1'b0});
      mv(1'b0, 16'h0005);
      chk(seen[4], 1'b0, "space dropped");
    end
    wr(flpc_pkg::FPC_IDX, 8'h00);
    mv(1'b0, 16'h0100);
    chk(seen, 5'b00100, "data space");
    wr(flpc_pkg::EEC_IDX, 8'h02);
    mv(1'b0, 16'h0100);
    chk(seen, 5'b01000, "eeprom latch");
    wr(flpc_pkg::EEC_IDX, 8'h00);
    @(posedge clk_i);
    ext_n <= 1'b0;
    settle(8);
    mv(1'b1, 16'h0100);
    chk(seen, 5'b00001, "external fetch");
    @(posedge clk_i);
    ext_n <= 1'b1;
    settle(8);
  endtask
  task automatic t_eeprom();
    wr(flpc_pkg::EWT_IDX, 8'h3c); // 5 x 12 MHz
    rd(flpc_pkg::EWT_IDX);
    chk(d, 32'h3c, "timer rw");
    wr(flpc_pkg::EEC_IDX, 8'h50);
    wr(flpc_pkg::EEC_IDX, 8'ha0);
    settle(0);
    chk(ebusy, 1'b1, "eeprom busy");
    for (lat = 0; lat < 400 && ebusy !== 1'b0; lat++) @(posedge clk_i);
    if (lat == 400) tmo("eeprom busy");
    rd(flpc_pkg::STAT_IDX);
    chk(d[flpc_pkg::IRQ_EDONE], 1'b1, "eeprom done");
  endtask
  task automatic t_sec();
    @(posedge clk_i);
    sec_d <= 8'h7e;
    sec_wr <= 1'b1;
    @(posedge clk_i);
    sec_wr <= 1'b0;
    settle(2);
    chk(sec, 8'hff, "no parallel mode");
    @(posedge clk_i);
    par_mode <= 1'b1;
    sec_wr <= 1'b1;
    @(posedge clk_i);
    sec_wr <= 1'b0;
    settle(2);
    chk(sec, 8'h7e, "parallel write");
    @(posedge clk_i);
    par_erase <= 1'b1;
    @(posedge clk_i);
    par_erase <= 1'b0;
    settle(2);
    chk(sec, flpc_pkg::SEC_ERASED, "chip erase");
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_launch();
    t_abort();
    t_moves();
    t_eeprom();
    t_sec();
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
